// >>> src/serial_memory_pkg.sv
/*
 * Shared constants and types of the two-wire serial memory slave: timing
 * figures with their derived cycle counts, address layout, message codes
 * and state encodings.
 * Assumes a 125 MHz system clock and a 64 ns link sampling clock.
 */
package serial_memory_pkg;

  // Clock periods
  localparam real CLK_SYS_PERIOD_NS = 8.0;
  localparam int LINK_PERIOD_NS = 64;

  // Input noise filter: pulses of this width or less must vanish
  localparam int GLITCH_NS = 50;
  // Two agreeing samples at least, so a pulse that hits one sample is dropped
  localparam int FILTER_SAMPLES = GLITCH_NS / LINK_PERIOD_NS + 2;

  // Internal write time, longest; rounded down to whole cycles
  localparam real INTERNAL_WRITE_TIME_MS = 5.0;
  localparam int INTERNAL_WRITE_CYCLES =
    $rtoi(INTERNAL_WRITE_TIME_MS * 1.0e6 / CLK_SYS_PERIOD_NS);
  localparam int WR_CNT_W = 20;

  // Power-up to ready, longest; rounded down to whole cycles
  localparam real POWER_UP_READY_DELAY_MS = 0.1;
  localparam int POWER_UP_READY_CYCLES =
    $rtoi(POWER_UP_READY_DELAY_MS * 1.0e6 / CLK_SYS_PERIOD_NS);
  localparam int PU_CNT_W = 14;

  // Memory organisation
  localparam int BYTE_W = 8;
  localparam int MEM_ADDR_W = 17;
  localparam int MEM_BYTES = 131072;
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_ADDR_W = 8;
  localparam logic [BYTE_W-1:0] ERASED_BYTE = 8'hff;

  // Slave address byte layout
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam int SA_TYPE_MSB = 7;
  localparam int SA_TYPE_LSB = 4;
  localparam int SA_SEL_MSB = 3;
  localparam int SA_SEL_LSB = 2;
  localparam int SA_TOP_BIT = 1;
  localparam int SA_RW_BIT = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Link to system messages
  localparam int FIFO_DEPTH = 4;
  localparam int MSG_W = 2 + MEM_ADDR_W;
  typedef enum logic [1:0] {
    MSG_SET_ADDR = 2'h0,
    MSG_WRITE = 2'h1,
    MSG_CONSUME = 2'h2,
    MSG_COMMIT = 2'h3
  } msg_kind_t;

  // Byte position within a write transaction
  typedef enum logic [1:0] {
    PH_DEV = 2'h0,
    PH_ADDR_HI = 2'h1,
    PH_ADDR_LO = 2'h3,
    PH_DATA = 2'h2
  } phase_t;

  // Link engine states, Gray along receive, ack, send, master ack
  typedef enum logic [2:0] {
    LK_IDLE = 3'h0,
    LK_RECV = 3'h1,
    LK_ACK = 3'h3,
    LK_SEND = 3'h2,
    LK_MACK = 3'h6
  } link_state_t;

  // Write cycle engine states
  typedef enum logic [1:0] {
    SY_IDLE = 2'h0,
    SY_COPY = 2'h1,
    SY_WAIT = 2'h3
  } sys_state_t;

endpackage : serial_memory_pkg

// >>> src/msg_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset; DEPTH a power of two.
 */
`timescale 1ns/100ps
module msg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_n_i, // Asynchronous reset, active low
  input wire logic in_valid_i, // Write side offers a word
  output logic in_ready_o, // Space available
  input wire logic [WIDTH-1:0] in_data_i, // Word to store
  output logic out_valid_o, // Word available
  input wire logic out_ready_i, // Read side takes the word
  output logic [WIDTH-1:0] out_data_o // Oldest word
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_t;

  fifo_t f;
  fifo_t next_f;
  logic [WIDTH-1:0] store [DEPTH];
  logic push;
  logic pop;

  // Full and empty come straight from the count, so they never lie
  assign in_ready_o = (f.count != (AW+1)'(DEPTH));
  assign out_valid_o = (f.count != '0);
  assign out_data_o = store[f.rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Pointer and level update
  always_comb begin
    next_f = f;
    if (push) begin
      next_f.wr_ptr = f.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_f.rd_ptr = f.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_f.count = f.count + 1'b1;
    end else if (pop && !push) begin
      next_f.count = f.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // Storage needs no reset; only slots below the count are ever read
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      store[f.wr_ptr] <= in_data_i;
    end
  end

endmodule : msg_fifo

// >>> src/serial_memory_bus_slave.sv
/*
 * Two-wire serial bus slave of a byte-organised nonvolatile memory.
 * The link half runs on clk_link_i: it synchronises and filters the bus
 * lines, decodes start, stop and bytes, and drives the data line low only.
 * The system half runs on clk_sys_i: memory array, page buffer, address
 * pointer, write cycle timer and power-up delay.
 * Assumes the pad resolves the data line from sda_o/sda_oe_o with a pull-up,
 * and that undriven strap and protect pads are pulled low by the pad.
 */
`timescale 1ns/100ps
// Operation
// - Master makes clock, start and stop; slave never drives the clock line.
// - Master and slave swap transmitter and receiver roles per transaction phase.
// - Sample incoming bits on clock rise, change outgoing bits on clock fall.
// - Slave only pulls data low or releases it, never drives high.
// - Two strap inputs select one of four devices; respond only on match.
// - Write-protect high refuses every write to the whole array.
// - Undriven protect and strap inputs count as low.
// - Pulses of 50 ns or less on clock and data are ignored.
// - Power-on trigger resets to standby, again on every reassertion.
// - Ready for commands within 0.1 ms after power is stable.
// - Address byte: 1010, two select bits, top address bit, read/write bit.
// - Acknowledge own address by holding data low during ninth clock.
// - No acknowledge of the address while a write cycle runs.
// - Protect sampled on last fall before first data byte; high means no acknowledge.
module serial_memory_bus_slave
  import serial_memory_pkg::*;
#(
  parameter int WRITE_CYCLES = INTERNAL_WRITE_CYCLES,
  parameter int READY_CYCLES = POWER_UP_READY_CYCLES
) (
  input wire logic clk_sys_i, // System clock, 125 MHz
  input wire logic rst_n_i, // Power-on reset trigger, active low
  input wire logic clk_link_i, // Link sampling clock
  input wire logic scl_i, // Serial clock line, input only
  input wire logic sda_i, // Serial data line level
  output logic sda_o, // Serial data drive level, always low
  output logic sda_oe_o, // Serial data pull-down enable
  input wire logic device_select_low_i, // Low device select strap
  input wire logic device_select_high_i, // High device select strap
  input wire logic write_protect_i, // Write protect, high refuses writes
  output logic ready_o, // Power-up delay has elapsed
  output logic write_busy_o // Internal write cycle running
);

  // Link domain state
  typedef struct packed {
    link_state_t st;
    phase_t ph;
    logic [3:0] bit_cnt;
    logic [BYTE_W-1:0] shreg;
    logic [BYTE_W-1:0] addr_hi;
    logic rw;
    logic top_bit;
    logic master_ack;
    logic wp_block;
    logic wrote;
    logic sda_oe;
    logic sda_lvl;
    logic req_tgl;
    logic [MSG_W-1:0] msg;
    logic scl_meta;
    logic scl_sync;
    logic sda_meta;
    logic sda_sync;
    logic [FILTER_SAMPLES-1:0] scl_hist;
    logic [FILTER_SAMPLES-1:0] sda_hist;
    logic scl_f;
    logic sda_f;
    logic wp_meta;
    logic wp_sync;
    logic [1:0] sel_meta;
    logic [1:0] sel_sync;
    logic busy_meta;
    logic busy_sync;
    logic ready_meta;
    logic ready_sync;
    logic ack_meta;
    logic ack_sync;
  } link_t;

  // System domain state
  typedef struct packed {
    sys_state_t st;
    logic [MEM_ADDR_W-1:0] ptr;
    logic [PAGE_BYTES-1:0] valid;
    logic [PAGE_ADDR_W-1:0] idx;
    logic [WR_CNT_W-1:0] timer;
    logic [PU_CNT_W-1:0] pu_cnt;
    logic ready;
    logic busy;
    logic req_meta;
    logic req_sync;
    logic req_seen;
  } sys_t;

  link_t l;
  link_t next_l;
  sys_t s;
  sys_t next_s;

  logic [BYTE_W-1:0] mem [MEM_BYTES];
  logic [BYTE_W-1:0] page_buf [PAGE_BYTES];
  logic [BYTE_W-1:0] rd_byte;

  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [MSG_W-1:0] fifo_out_data;
  msg_kind_t out_kind;
  logic mem_we;
  logic [MEM_ADDR_W-1:0] mem_waddr;
  logic page_we;
  logic [PAGE_ADDR_W-1:0] page_waddr;

  // Outputs straight from flip-flops
  assign sda_o = l.sda_lvl;
  assign sda_oe_o = l.sda_oe;
  assign ready_o = s.ready;
  assign write_busy_o = s.busy;

  // Link engine: filter, conditions, byte framing and acknowledge
  always_comb begin : link_next
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic msg_idle;
    logic sel_match;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_ev = 1'b0;
    stop_ev = 1'b0;
    msg_idle = 1'b0;
    sel_match = 1'b0;
    next_l = l;
    // Two flops per pad before anything looks at it
    next_l.scl_meta = scl_i;
    next_l.scl_sync = l.scl_meta;
    next_l.sda_meta = sda_i;
    next_l.sda_sync = l.sda_meta;
    next_l.wp_meta = write_protect_i;
    next_l.wp_sync = l.wp_meta;
    next_l.sel_meta = {device_select_high_i, device_select_low_i};
    next_l.sel_sync = l.sel_meta;
    next_l.busy_meta = s.busy;
    next_l.busy_sync = l.busy_meta;
    next_l.ready_meta = s.ready;
    next_l.ready_sync = l.ready_meta;
    next_l.ack_meta = s.req_seen;
    next_l.ack_sync = l.ack_meta;
    // A level only counts once every sample agrees, so short pulses vanish
    next_l.scl_hist = {l.scl_hist[FILTER_SAMPLES-2:0], l.scl_sync};
    next_l.sda_hist = {l.sda_hist[FILTER_SAMPLES-2:0], l.sda_sync};
    if (&l.scl_hist) begin
      next_l.scl_f = 1'b1;
    end else if (~|l.scl_hist) begin
      next_l.scl_f = 1'b0;
    end
    if (&l.sda_hist) begin
      next_l.sda_f = 1'b1;
    end else if (~|l.sda_hist) begin
      next_l.sda_f = 1'b0;
    end
    // Both lines share one filter delay, so their order is kept
    scl_rise = next_l.scl_f & ~l.scl_f;
    scl_fall = ~next_l.scl_f & l.scl_f;
    start_ev = l.scl_f & next_l.scl_f & l.sda_f & ~next_l.sda_f;
    stop_ev = l.scl_f & next_l.scl_f & ~l.sda_f & next_l.sda_f;
    msg_idle = (l.req_tgl == l.ack_sync);
    sel_match = (l.shreg[SA_SEL_MSB:SA_SEL_LSB] == l.sel_sync);

    if (stop_ev) begin
      // Stop ends every command; after data bytes it starts the write cycle
      if (l.wrote) begin
        next_l.msg = {MSG_COMMIT, {MEM_ADDR_W{1'b0}}};
        next_l.req_tgl = ~l.req_tgl;
      end
      next_l.wrote = 1'b0;
      next_l.sda_oe = 1'b0;
      next_l.st = LK_IDLE;
    end else if (start_ev) begin
      // Start or repeated start; unfinished data is not committed
      next_l.st = LK_RECV;
      next_l.ph = PH_DEV;
      next_l.bit_cnt = 4'h0;
      next_l.sda_oe = 1'b0;
      next_l.wp_block = 1'b0;
      next_l.wrote = 1'b0;
    end else begin
      unique case (l.st)
        LK_IDLE: begin
          next_l.sda_oe = 1'b0;
        end
        LK_RECV: begin
          if (scl_rise) begin
            next_l.shreg = {l.shreg[BYTE_W-2:0], l.sda_f};
            next_l.bit_cnt = l.bit_cnt + 4'h1;
          end else if (scl_fall && l.bit_cnt == BITS_PER_BYTE) begin
            // Master now releases data; slave becomes transmitter of the ack
            unique case (l.ph)
              PH_DEV: begin
                if (l.shreg[SA_TYPE_MSB:SA_TYPE_LSB] == DEV_TYPE_CODE && sel_match
                    && l.ready_sync && !l.busy_sync && msg_idle) begin
                  next_l.sda_oe = 1'b1;
                  next_l.st = LK_ACK;
                  next_l.rw = l.shreg[SA_RW_BIT];
                  next_l.top_bit = l.shreg[SA_TOP_BIT];
                end else begin
                  next_l.st = LK_IDLE;
                end
              end
              PH_ADDR_HI: begin
                next_l.addr_hi = l.shreg;
                next_l.sda_oe = 1'b1;
                next_l.st = LK_ACK;
              end
              PH_ADDR_LO: begin
                next_l.msg = {MSG_SET_ADDR, l.top_bit, l.addr_hi, l.shreg};
                next_l.req_tgl = ~l.req_tgl;
                next_l.sda_oe = 1'b1;
                next_l.st = LK_ACK;
              end
              PH_DATA: begin
                // Protected or still handing over the last byte: no ack
                if (!l.wp_block && msg_idle) begin
                  next_l.msg = {MSG_WRITE, {(MEM_ADDR_W-BYTE_W){1'b0}}, l.shreg};
                  next_l.req_tgl = ~l.req_tgl;
                  next_l.wrote = 1'b1;
                  next_l.sda_oe = 1'b1;
                  next_l.st = LK_ACK;
                end else begin
                  next_l.st = LK_IDLE;
                end
              end
            endcase
          end
        end
        LK_ACK: begin
          if (scl_fall) begin
            next_l.bit_cnt = 4'h0;
            if (l.ph == PH_DEV && l.rw) begin
              // Read: first bit goes out on the fall ending the ack
              next_l.shreg = rd_byte;
              next_l.sda_oe = ~rd_byte[BYTE_W-1];
              next_l.msg = {MSG_CONSUME, {MEM_ADDR_W{1'b0}}};
              next_l.req_tgl = ~l.req_tgl;
              next_l.st = LK_SEND;
            end else begin
              next_l.sda_oe = 1'b0;
              next_l.st = LK_RECV;
              unique case (l.ph)
                PH_DEV: next_l.ph = PH_ADDR_HI;
                PH_ADDR_HI: next_l.ph = PH_ADDR_LO;
                PH_ADDR_LO: begin
                  next_l.ph = PH_DATA;
                  next_l.wp_block = l.wp_sync;
                end
                PH_DATA: next_l.ph = PH_DATA;
              endcase
            end
          end
        end
        LK_SEND: begin
          if (scl_rise) begin
            next_l.bit_cnt = l.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (l.bit_cnt == BITS_PER_BYTE) begin
              next_l.sda_oe = 1'b0; // Release for the master's ack
              next_l.st = LK_MACK;
            end else begin
              next_l.shreg = {l.shreg[BYTE_W-2:0], 1'b0};
              next_l.sda_oe = ~l.shreg[BYTE_W-2];
            end
          end
        end
        LK_MACK: begin
          if (scl_rise) begin
            next_l.master_ack = ~l.sda_f;
          end else if (scl_fall) begin
            next_l.bit_cnt = 4'h0;
            if (l.master_ack) begin
              next_l.shreg = rd_byte;
              next_l.sda_oe = ~rd_byte[BYTE_W-1];
              next_l.msg = {MSG_CONSUME, {MEM_ADDR_W{1'b0}}};
              next_l.req_tgl = ~l.req_tgl;
              next_l.st = LK_SEND;
            end else begin
              next_l.st = LK_IDLE; // No ack ends the read; wait for stop
            end
          end
        end
        default: begin
          next_l.st = LK_IDLE;
          next_l.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Power-on trigger resets the whole link side
  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // Message handshake into the FIFO; the ack toggle returns only once stored
  assign fifo_in_valid = (s.req_sync != s.req_seen);
  assign fifo_out_ready = (s.st == SY_IDLE);
  assign out_kind = msg_kind_t'(fifo_out_data[MSG_W-1:MEM_ADDR_W]);

  msg_fifo #(
    .WIDTH(MSG_W),
    .DEPTH(FIFO_DEPTH)
  ) u_msg_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(l.msg),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // Page buffer and array write strobes
  assign page_we = fifo_out_valid && fifo_out_ready && out_kind == MSG_WRITE;
  assign page_waddr = s.ptr[PAGE_ADDR_W-1:0];
  assign mem_we = (s.st == SY_COPY) && s.valid[s.idx];
  assign mem_waddr = {s.ptr[MEM_ADDR_W-1:PAGE_ADDR_W], s.idx};

  // System engine: pointer, page collection, write cycle, power-up delay
  always_comb begin
    next_s = s;
    // The message word is held by the link until acknowledged, so it is stable here
    next_s.req_meta = l.req_tgl;
    next_s.req_sync = s.req_meta;
    if (fifo_in_valid && fifo_in_ready) begin
      next_s.req_seen = s.req_sync;
    end
    if (!s.ready) begin
      if (s.pu_cnt == PU_CNT_W'(READY_CYCLES - 1)) begin
        next_s.ready = 1'b1;
      end else begin
        next_s.pu_cnt = s.pu_cnt + 1'b1;
      end
    end
    unique case (s.st)
      SY_IDLE: begin
        if (fifo_out_valid) begin
          unique case (out_kind)
            MSG_SET_ADDR: begin
              next_s.ptr = fifo_out_data[MEM_ADDR_W-1:0];
              next_s.valid = '0;
            end
            MSG_WRITE: begin
              // Counter wraps inside the page, later bytes overwrite earlier
              next_s.valid[page_waddr] = 1'b1;
              next_s.ptr[PAGE_ADDR_W-1:0] = page_waddr + 1'b1;
            end
            MSG_CONSUME: begin
              next_s.ptr = s.ptr + 1'b1; // Sequential read wraps the whole array
            end
            MSG_COMMIT: begin
              if (|s.valid) begin
                next_s.st = SY_COPY;
                next_s.busy = 1'b1;
                next_s.idx = '0;
                next_s.timer = '0;
              end
            end
          endcase
        end
      end
      SY_COPY: begin
        next_s.timer = s.timer + 1'b1;
        next_s.idx = s.idx + 1'b1;
        if (s.idx == PAGE_ADDR_W'(PAGE_BYTES - 1)) begin
          next_s.st = SY_WAIT;
        end
      end
      SY_WAIT: begin
        // Fixed time from the commit message, never more than the internal write time
        next_s.timer = s.timer + 1'b1;
        if (s.timer == WR_CNT_W'(WRITE_CYCLES - 1)) begin
          next_s.st = SY_IDLE;
          next_s.busy = 1'b0;
          next_s.valid = '0;
        end
      end
      default: begin
        next_s.st = SY_IDLE;
        next_s.busy = 1'b0;
      end
    endcase
  end

  // Brown-out reassertion returns the system side to reset as well
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Array and page buffer; read byte follows the pointer and moves after a
  // set-address, write or consume, long before the link loads it again
  always_ff @(posedge clk_sys_i) begin
    if (page_we) begin
      page_buf[page_waddr] <= fifo_out_data[BYTE_W-1:0];
    end
    if (mem_we) begin
      mem[mem_waddr] <= page_buf[s.idx];
    end
    rd_byte <= mem[s.ptr];
  end

  // Delivered erased
  initial begin
    for (int i = 0; i < MEM_BYTES; i++) begin
      mem[i] = ERASED_BYTE;
    end
  end

endmodule : serial_memory_bus_slave

// >>> verification/serial_memory_bus_slave_chk.sv
/* Port checker of the serial memory slave.
   Assumes binding into the slave; link outputs are sampled on clk_sys_i. */
`timescale 1ns/100ps
module serial_memory_bus_slave_chk #(
  parameter int WRITE_CYCLES = 4000,
  parameter int READY_CYCLES = 20
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic scl_i, // Bus clock
  input wire logic sda_o, // Data drive level
  input wire logic sda_oe_o, // Data pull-down enable
  input wire logic ready_o, // Ready flag
  input wire logic write_busy_o // Write cycle flag
);
  logic [13:0] rdy_cnt;
  logic [19:0] busy_cnt;
  // Edges up to ready, and length of each busy spell
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdy_cnt <= 14'h0;
      busy_cnt <= 20'h0;
    end else begin
      rdy_cnt <= ready_o ? rdy_cnt : rdy_cnt + 14'h1;
      busy_cnt <= write_busy_o ? busy_cnt + 20'h1 : 20'h0;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  drive_low_only_a: assert property (sda_o == 1'b0)
    else $error("data driven high");
  no_ack_unready_a: assert property (!ready_o |-> !sda_oe_o)
    else $error("drive before ready");
  busy_nack_a: assert property (write_busy_o && $past(write_busy_o) |-> !sda_oe_o)
    else $error("drive while busy");
  oe_on_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data changed with clock high");
  ready_delay_a: assert property ($rose(ready_o) |-> rdy_cnt == READY_CYCLES)
    else $error("ready delay wrong");
  busy_len_a: assert property ($fell(write_busy_o) |->
    busy_cnt inside {[WRITE_CYCLES:WRITE_CYCLES + 2]})
    else $error("write cycle length wrong");
  ready_holds_a: assert property (ready_o |=> ready_o)
    else $error("ready dropped");
  ack_stands_a: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("drive too short");
  cover property ($rose(ready_o));
  cover property ($rose(write_busy_o));
  cover property ($rose(sda_oe_o));
endmodule : serial_memory_bus_slave_chk

// >>> verification/bus_master_model.sv
/* Two-wire bus master model: start, stop, byte transfer, clock glitch.
   Assumes a pull-up on the data line; timing counts falling clk_i edges. */
`timescale 1ns/100ps
module bus_master_model (
  input wire logic clk_i, // Bench clock, timing base
  input wire logic sda_i, // Resolved data line
  output logic scl_o, // Bus clock, always driven
  output logic sda_low_o // High pulls data low
);
  // Idle bus: clock stands high
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Data falls while clock high; also serves as repeated start
  task automatic start();
    sda_low_o = 1'b0;
    w(50);
    scl_o = 1'b1;
    w(50);
    sda_low_o = 1'b1;
    w(50);
    scl_o = 1'b0;
  endtask
  // Data rises while clock high
  task automatic stop();
    w(50);
    sda_low_o = 1'b1;
    w(50);
    scl_o = 1'b1;
    w(50);
    sda_low_o = 1'b0;
    w(50);
  endtask
  // Data set mid-low, sampled mid-high; 1.6 us bit fits 1 MHz grade
  task automatic bit_io(input logic b, output logic r);
    w(50);
    sda_low_o = !b;
    w(50);
    scl_o = 1'b1;
    w(50);
    r = sda_i;
    w(50);
    scl_o = 1'b0;
  endtask
  // Release lets the slave send; mack is the ninth bit
  task automatic xbyte(input logic [7:0] d, input logic mack, output logic [7:0] r,
                       output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(mack, ack);
  endtask
  // 40 ns clock pulse, short enough to be filtered
  task automatic glitch();
    w(25);
    scl_o = 1'b1;
    w(5);
    scl_o = 1'b0;
  endtask
endmodule : bus_master_model

// >>> verification/testbench.sv
/* Self-checking bench of the serial memory slave against a byte map.
   Assumes the master model drives the bus; data line has a pull-up. */
`timescale 1ns/100ps
bind serial_memory_bus_slave serial_memory_bus_slave_chk #(
  .WRITE_CYCLES(WRITE_CYCLES),
  .READY_CYCLES(READY_CYCLES)
) chk_i (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .scl_i(scl_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .ready_o(ready_o),
  .write_busy_o(write_busy_o)
);
module testbench;
  import serial_memory_pkg::*;
  localparam int WR_CYC = 4000;
  localparam int RDY_CYC = 20;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst_n = 1'b0;
  logic sel_low = 1'b0;
  logic sel_high = 1'b0;
  logic wp = 1'b0;
  logic scl;
  logic m_low;
  logic sda_o;
  logic sda_oe;
  logic ready;
  logic busy;
  logic sda;
  logic [7:0] rb;
  logic ak;
  logic [7:0] mem [int];
  int n_mismatch = 0;
  int compares = 0;
  // Open-drain data line with pull-up
  assign sda = !m_low && (sda_oe ? sda_o : 1'b1);
  always #4 clk_sys = ~clk_sys;
  // Link clock free running, phase unrelated to the system clock
  initial begin
    #13.3;
    forever #32 clk_link = ~clk_link;
  end
  serial_memory_bus_slave #(.WRITE_CYCLES(WR_CYC), .READY_CYCLES(RDY_CYC))
    serial_memory_bus_slave_i (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .clk_link_i(clk_link),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .device_select_low_i(sel_low), .device_select_high_i(sel_high),
    .write_protect_i(wp), .ready_o(ready), .write_busy_o(busy));
  bus_master_model m (.clk_i(clk_sys), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Eight-cycle reset pulse; both domains clear asynchronously, then ready timing
  task automatic por();
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk(ready, 1'b0);
    rst_n = 1'b1;
    repeat (RDY_CYC - 1) @(negedge clk_sys);
    chk(ready, 1'b0);
    @(negedge clk_sys);
    chk(ready, 1'b1);
    repeat (40) @(negedge clk_sys);
  endtask
  task automatic hdr(input logic [3:0] ty, input logic [1:0] s, input logic t, input logic rw);
    m.xbyte({ty, s, t, rw}, 1'b1, rb, ak);
  endtask
  // Write header and both address bytes
  task automatic setp(input logic [16:0] a);
    m.start();
    hdr(DEV_TYPE_CODE, {sel_high, sel_low}, a[16], 1'b0);
    chk(ak, 1'b0);
    m.xbyte(a[15:8], 1'b1, rb, ak);
    m.xbyte(a[7:0], 1'b1, rb, ak);
    chk(ak, 1'b0);
  endtask
  // Refused data leaves the map untouched; pointer wraps in the page
  task automatic wr(input logic [16:0] a, input int n, input logic nak);
    logic [7:0] d;
    setp(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      m.xbyte(d, 1'b1, rb, ak);
      chk(ak, nak);
      if (!nak)
        mem[{a[16:8], 8'(a[7:0] + i)}] = d;
    end
    m.stop();
  endtask
  task automatic rd(input logic [16:0] a, input int n);
    logic [16:0] p;
    setp(a);
    m.start();
    hdr(DEV_TYPE_CODE, {sel_high, sel_low}, a[16], 1'b1);
    chk(ak, 1'b0);
    for (int i = 0; i < n; i++) begin
      m.xbyte(8'hff, i == n - 1, rb, ak);
      // Sequential read wraps at the end of the 17-bit array
      p = a + 17'(i);
      chk(rb, mem.exists(p) ? mem[p] : ERASED_BYTE);
    end
    m.stop();
  endtask
  initial begin
    logic [16:0] a;
    void'($urandom(32'h638c087e));
    @(negedge clk_sys);
    {sel_high, sel_low} = 2'($urandom);
    por();
    a = 17'($urandom) | 17'h000ff;
    wr(a, 2, 1'b0);
    for (int k = 0; k < 100 && busy !== 1'b1; k++)
      @(negedge clk_sys);
    chk(busy, 1'b1);
    m.start();
    hdr(DEV_TYPE_CODE, {sel_high, sel_low}, a[16], 1'b1);
    chk(ak, 1'b1);
    m.stop();
    for (int k = 0; k < WR_CYC && busy !== 1'b0; k++)
      @(negedge clk_sys);
    chk(busy, 1'b0);
    rd(a, 2);
    rd({a[16:8], 8'h00}, 1);
    // Wrong straps and wrong type nibble go unanswered
    for (int j = 1; j < 4; j++) begin
      m.start();
      hdr(j == 3 ? 4'hb : DEV_TYPE_CODE, {sel_high, sel_low} ^ 2'(j % 3), 1'b0, 1'b0);
      chk(ak, 1'b1);
      m.stop();
    end
    @(negedge clk_sys);
    wp = 1'b1;
    wr(a, 1, 1'b1);
    repeat (50) @(negedge clk_sys);
    chk(busy, 1'b0);
    wp = 1'b0;
    m.start();
    m.glitch();
    hdr(DEV_TYPE_CODE, {sel_high, sel_low}, 1'b0, 1'b0);
    chk(ak, 1'b0);
    m.stop();
    por();
    rd(a, 2);
    give_verdict();
  end
  // Hang guard: the run needs about 62k clocks, give up at 90k
  initial begin
    #720_000;
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
